// file: pkg/its_pkg.sv
// constants, operation codes and timing table for the instruction timing sequencer
// Contract
// - register-form extended add and subtract take 4 clocks (1/0) for byte or word, 8 (1/0) for long.
// - memory-form extended add or subtract take 18 (3/1) or 30 (5/2); memory compare 12 (3/0) or 20 (5/0).
// - decimal add or subtract with extend take 6 (1/0) on registers and 18 (3/1) on memory.
// - immediate and, exclusive-or and or to the code byte or status word take 20 clocks (3/0).
// - external reset takes 132 (1/0), halt takes 4 (0/0), nop/extend/swap/stack moves 4 (1/0), exchange 6.
// - status word write 12 (2/0), code byte write 12 (1/0), status read 6 (1/0) to register or 8 (1/1) to memory.
// - entries that need address calculation add that calculation's clocks, reads and writes.
// - link 16 (2/2), unlink 12 (3/0), subroutine return 16 (4/0), exception return 20 (5/0), restore return 20 (2/0).
// - peripheral lane move takes 16 clocks for word and 24 for long, with the listed bus cycles.
// - address and bus error processing take 50 clocks (4/7), covering stacking, vector and first fetch.
// - interrupt processing takes 44 clocks (5/3) with a four-clock acknowledge cycle.
// - after reset and halt are first sampled negated, execution starts 40 clocks later after 6 reads.
// - illegal, privilege, trace and trap take 34 (4/3), overflow trap 34 (5/3), bounds 40, divide-by-zero 38.
package its_pkg;

  // ********************************************************
  // operation codes
  // ********************************************************
  typedef enum logic [5:0] {
    OP_EXTENDED_ADD_RR_BW, OP_EXTENDED_ADD_RR_L, OP_EXTENDED_ADD_MM_BW, OP_EXTENDED_ADD_MM_L,
    OP_EXTENDED_SUBTRACT_RR_BW, OP_EXTENDED_SUBTRACT_RR_L, OP_EXTENDED_SUBTRACT_MM_BW,
    OP_EXTENDED_SUBTRACT_MM_L, OP_MEMORY_COMPARE_BW, OP_MEMORY_COMPARE_L,
    OP_DECIMAL_ADD_EXTEND_R, OP_DECIMAL_ADD_EXTEND_M, OP_DECIMAL_SUBTRACT_EXTEND_R,
    OP_DECIMAL_SUBTRACT_EXTEND_M, OP_AND_IMM_CODE, OP_AND_IMM_STATUS, OP_XOR_IMM_CODE,
    OP_XOR_IMM_STATUS, OP_OR_IMM_CODE, OP_OR_IMM_STATUS, OP_STATUS_READ_REG,
    OP_STATUS_READ_MEM, OP_CODE_WRITE, OP_STATUS_WRITE, OP_REGISTER_EXCHANGE, OP_EXTEND,
    OP_LINK, OP_USP_READ, OP_USP_WRITE, OP_NOP, OP_EXT_RESET, OP_EXCEPTION_RETURN,
    OP_RETURN_RESTORE_CODES, OP_SUB_RETURN, OP_HALT_WAIT, OP_SWAP, OP_FRAME_UNLINK,
    OP_LANE_MOVE_W_RM, OP_LANE_MOVE_W_MR, OP_LANE_MOVE_L_RM, OP_LANE_MOVE_L_MR,
    OP_EXC_ADDRESS_ERROR, OP_EXC_BUS_ERROR, OP_EXC_BOUNDS_CHECK, OP_EXC_DIVIDE_ZERO,
    OP_EXC_ILLEGAL, OP_EXC_INTERRUPT, OP_EXC_PRIVILEGE, OP_EXC_TRACE, OP_EXC_TRAP,
    OP_EXC_OVERFLOW_TRAP
  } its_op_t;

  localparam int unsigned ITS_CLK_W = 8;
  localparam int unsigned ITS_CYC_W = 4;
  // one bus cycle without wait states
  localparam logic [ITS_CLK_W-1:0] ITS_BUS_CLKS = 8'h04;
  // reset-to-execution start figures
  localparam logic [ITS_CLK_W-1:0] ITS_RESET_CLKS = 8'h28;
  localparam logic [ITS_CYC_W-1:0] ITS_RESET_READS = 4'h6;
  // flag: entry takes address calculation on top
  localparam int unsigned ITS_ENT_W = ITS_CLK_W + 2*ITS_CYC_W + 1;

  // ********************************************************
  // timing entry packer: clocks, reads, writes, address-calc flag
  // ********************************************************
  function automatic logic [ITS_ENT_W-1:0] its_ent(input int c, input int r, input int w,
                                                   input bit ea);
    its_ent = {c[ITS_CLK_W-1:0], r[ITS_CYC_W-1:0], w[ITS_CYC_W-1:0], ea};
  endfunction : its_ent

  function automatic logic [ITS_ENT_W-1:0] its_lookup(input its_op_t op);
    case (op)
      OP_EXTENDED_ADD_RR_BW, OP_EXTENDED_SUBTRACT_RR_BW: its_lookup = its_ent(4, 1, 0, 0);
      OP_EXTENDED_ADD_RR_L, OP_EXTENDED_SUBTRACT_RR_L: its_lookup = its_ent(8, 1, 0, 0);
      OP_EXTENDED_ADD_MM_BW, OP_EXTENDED_SUBTRACT_MM_BW: its_lookup = its_ent(18, 3, 1, 0);
      OP_EXTENDED_ADD_MM_L, OP_EXTENDED_SUBTRACT_MM_L: its_lookup = its_ent(30, 5, 2, 0);
      OP_MEMORY_COMPARE_BW: its_lookup = its_ent(12, 3, 0, 0);
      OP_MEMORY_COMPARE_L: its_lookup = its_ent(20, 5, 0, 0);
      OP_DECIMAL_ADD_EXTEND_R, OP_DECIMAL_SUBTRACT_EXTEND_R: its_lookup = its_ent(6, 1, 0, 0);
      OP_DECIMAL_ADD_EXTEND_M, OP_DECIMAL_SUBTRACT_EXTEND_M: its_lookup = its_ent(18, 3, 1, 0);
      OP_AND_IMM_CODE, OP_AND_IMM_STATUS, OP_XOR_IMM_CODE, OP_XOR_IMM_STATUS,
      OP_OR_IMM_CODE, OP_OR_IMM_STATUS: its_lookup = its_ent(20, 3, 0, 0);
      OP_STATUS_READ_REG: its_lookup = its_ent(6, 1, 0, 0);
      OP_STATUS_READ_MEM: its_lookup = its_ent(8, 1, 1, 1);
      OP_CODE_WRITE: its_lookup = its_ent(12, 1, 0, 1);
      OP_STATUS_WRITE: its_lookup = its_ent(12, 2, 0, 1);
      OP_REGISTER_EXCHANGE: its_lookup = its_ent(6, 1, 0, 0);
      OP_EXTEND, OP_USP_READ, OP_USP_WRITE, OP_NOP, OP_SWAP: its_lookup = its_ent(4, 1, 0, 0);
      OP_EXT_RESET: its_lookup = its_ent(132, 1, 0, 0);
      OP_HALT_WAIT: its_lookup = its_ent(4, 0, 0, 0);
      OP_LINK: its_lookup = its_ent(16, 2, 2, 0);
      OP_FRAME_UNLINK: its_lookup = its_ent(12, 3, 0, 0);
      OP_SUB_RETURN: its_lookup = its_ent(16, 4, 0, 0);
      OP_EXCEPTION_RETURN: its_lookup = its_ent(20, 5, 0, 0);
      OP_RETURN_RESTORE_CODES: its_lookup = its_ent(20, 2, 0, 0);
      OP_LANE_MOVE_W_RM: its_lookup = its_ent(16, 2, 2, 0);
      OP_LANE_MOVE_W_MR: its_lookup = its_ent(16, 4, 0, 0);
      OP_LANE_MOVE_L_RM: its_lookup = its_ent(24, 2, 4, 0);
      OP_LANE_MOVE_L_MR: its_lookup = its_ent(24, 6, 0, 0);
      OP_EXC_ADDRESS_ERROR, OP_EXC_BUS_ERROR: its_lookup = its_ent(50, 4, 7, 0);
      OP_EXC_INTERRUPT: its_lookup = its_ent(44, 5, 3, 0);
      OP_EXC_BOUNDS_CHECK: its_lookup = its_ent(40, 4, 3, 1);
      OP_EXC_DIVIDE_ZERO: its_lookup = its_ent(38, 4, 3, 1);
      OP_EXC_OVERFLOW_TRAP: its_lookup = its_ent(34, 5, 3, 0);
      OP_EXC_ILLEGAL, OP_EXC_PRIVILEGE, OP_EXC_TRACE, OP_EXC_TRAP:
        its_lookup = its_ent(34, 4, 3, 0);
      default: its_lookup = its_ent(4, 1, 0, 0);
    endcase
  endfunction : its_lookup

endpackage : its_pkg

// file: src/its_sync.sv
// two-flop synchroniser for one asynchronous level
`timescale 1ns/1ns
`default_nettype none
module its_sync
  import its_pkg::*;
#(
  parameter logic RESET_VAL = 1'b0
)
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // level in and out
  input wire logic din,
  output logic dout
);

  logic meta_ff;
  logic sync_ff;

  // first flop is read only by the second
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      meta_ff <= RESET_VAL;
      sync_ff <= RESET_VAL;
    end
    else
    begin
      meta_ff <= din;
      sync_ff <= meta_ff;
    end
  end

  assign dout = sync_ff;

endmodule : its_sync
`default_nettype wire

// file: src/its_sequencer.sv
// instruction timing sequencer: paces each operation through clocks and bus cycles
`timescale 1ns/1ns
`default_nettype none
module its_sequencer
  import its_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // core reset and halt pins, active low, asynchronous
  input wire logic reset_in_b,
  input wire logic halt_in_b,
  // operation request
  input wire logic op_valid,
  input wire its_op_t op_code,
  output logic op_ready,
  // address-calculation cost added to flagged entries
  input wire logic [ITS_CLK_W-1:0] ea_clks,
  input wire logic [ITS_CYC_W-1:0] ea_reads,
  input wire logic [ITS_CYC_W-1:0] ea_writes,
  // bus cycle strobes and completion from the bus partner
  output logic bus_req,
  output logic bus_write,
  input wire logic bus_ack_b,
  // status
  output logic running,
  output logic op_done,
  output logic [ITS_CLK_W+1:0] op_clocks
);

  // ********************************************************
  // pin synchronisation
  // ********************************************************
  logic reset_s_b;
  logic halt_s_b;
  logic ack_s_b;

  its_sync #(.RESET_VAL(1'b0)) u_sync_rst (.clk(clk), .rst_b(rst_b), .din(reset_in_b),
    .dout(reset_s_b));
  its_sync #(.RESET_VAL(1'b0)) u_sync_halt (.clk(clk), .rst_b(rst_b), .din(halt_in_b),
    .dout(halt_s_b));
  its_sync #(.RESET_VAL(1'b1)) u_sync_ack (.clk(clk), .rst_b(rst_b), .din(bus_ack_b),
    .dout(ack_s_b));

  // ********************************************************
  // sequencer state
  // ********************************************************
  typedef enum logic [2:0] {S_RESET, S_IDLE, S_BUS, S_INTERNAL, S_DONE} its_state_t;

  its_state_t state_ff, nxt_state;
  logic [ITS_CLK_W:0] rem_ff, nxt_rem;      // internal clocks still owed
  logic [ITS_CYC_W:0] rd_ff, nxt_rd;        // reads still owed
  logic [ITS_CYC_W:0] wr_ff, nxt_wr;        // writes still owed
  logic [1:0] phase_ff, nxt_phase;          // clock within a bus cycle
  logic write_ff, nxt_write;
  logic [ITS_CLK_W+1:0] cnt_ff, nxt_cnt;    // elapsed clocks of this operation
  logic [ITS_CLK_W+1:0] done_cnt_ff, nxt_done_cnt;
  logic run_ff, nxt_run;

  logic [ITS_ENT_W-1:0] ent;
  logic [ITS_CLK_W:0] tot_clk;
  logic [ITS_CYC_W:0] tot_rd;
  logic [ITS_CYC_W:0] tot_wr;
  logic [ITS_CLK_W+1:0] bus_clk;

  // table lookup with address calculation folded in
  always_comb
  begin
    ent = its_lookup(op_code);
    tot_clk = {1'b0, ent[ITS_ENT_W-1 -: ITS_CLK_W]};
    tot_rd = {1'b0, ent[2*ITS_CYC_W -: ITS_CYC_W]};
    tot_wr = {1'b0, ent[ITS_CYC_W -: ITS_CYC_W]};
    if (ent[0])
    begin
      tot_clk = tot_clk + {1'b0, ea_clks};
      tot_rd = tot_rd + {1'b0, ea_reads};
      tot_wr = tot_wr + {1'b0, ea_writes};
    end
    // bus cycles own four clocks each of the total
    bus_clk = ({1'b0, tot_rd} + {1'b0, tot_wr}) * ITS_BUS_CLKS;
  end

  // next-state logic
  always_comb
  begin
    nxt_state = state_ff;
    nxt_rem = rem_ff;
    nxt_rd = rd_ff;
    nxt_wr = wr_ff;
    nxt_phase = phase_ff;
    nxt_write = write_ff;
    nxt_cnt = cnt_ff;
    nxt_done_cnt = done_cnt_ff;
    nxt_run = run_ff;
    case (state_ff)
      S_RESET:
      begin
        // held while either pin is asserted; restart from the start
        nxt_run = 1'b0;
        if (reset_s_b && halt_s_b && !run_ff)
        begin
          // start-up: vector fetch then first instruction
          nxt_run = 1'b1;
          nxt_rd = {1'b0, ITS_RESET_READS};
          nxt_wr = '0;
          nxt_rem = {1'b0, ITS_RESET_CLKS} - {1'b0, ITS_RESET_READS, 2'b00};
          nxt_cnt = '0;
          nxt_phase = 2'b00;
          nxt_write = 1'b0;
          nxt_state = S_BUS;
        end
      end
      S_IDLE:
      begin
        if (op_valid)
        begin
          nxt_rd = tot_rd;
          nxt_wr = tot_wr;
          // clocks beyond the bus cycles are spent internally
          nxt_rem = (tot_clk > bus_clk[ITS_CLK_W:0]) ? tot_clk - bus_clk[ITS_CLK_W:0] : '0;
          nxt_cnt = '0;
          nxt_phase = 2'b00;
          nxt_write = (tot_rd == '0) && (tot_wr != '0);
          nxt_state = ((tot_rd | tot_wr) != '0) ? S_BUS : S_INTERNAL;
        end
      end
      S_BUS:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        // last phase stretches until the partner acknowledges
        if (phase_ff != 2'b11)
          nxt_phase = phase_ff + 1'b1;
        else if (!ack_s_b)
        begin
          nxt_phase = 2'b00;
          if (write_ff)
            nxt_wr = wr_ff - 1'b1;
          else
            nxt_rd = rd_ff - 1'b1;
          // reads first, then writes, then the internal remainder
          if (!write_ff && rd_ff > 1)
            nxt_write = 1'b0;
          else if ((write_ff ? wr_ff - 1'b1 : wr_ff) != '0)
            nxt_write = 1'b1;
          else
          begin
            // drop the write flag so it never shows outside a bus cycle
            nxt_write = 1'b0;
            nxt_state = (rem_ff != '0) ? S_INTERNAL : S_DONE;
          end
        end
      end
      S_INTERNAL:
      begin
        nxt_cnt = cnt_ff + 1'b1;
        if (rem_ff <= 1)
        begin
          nxt_rem = '0;
          nxt_state = S_DONE;
        end
        else
          nxt_rem = rem_ff - 1'b1;
      end
      S_DONE:
      begin
        nxt_done_cnt = cnt_ff;
        nxt_state = S_IDLE;
      end
      default: nxt_state = S_RESET;
    endcase
    // reset or halt asserted aborts any sequence
    if (!reset_s_b || !halt_s_b)
    begin
      nxt_state = S_RESET;
      nxt_run = 1'b0;
      // a write cut short must not leave bus_write standing
      nxt_write = 1'b0;
    end
  end

  // state registers
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state_ff <= S_RESET;
      rem_ff <= '0;
      rd_ff <= '0;
      wr_ff <= '0;
      phase_ff <= 2'b00;
      write_ff <= 1'b0;
      cnt_ff <= '0;
      done_cnt_ff <= '0;
      run_ff <= 1'b0;
    end
    else
    begin
      state_ff <= nxt_state;
      rem_ff <= nxt_rem;
      rd_ff <= nxt_rd;
      wr_ff <= nxt_wr;
      phase_ff <= nxt_phase;
      write_ff <= nxt_write;
      cnt_ff <= nxt_cnt;
      done_cnt_ff <= nxt_done_cnt;
      run_ff <= nxt_run;
    end
  end

  // ********************************************************
  // outputs
  // ********************************************************
  assign op_ready = (state_ff == S_IDLE);
  assign bus_req = (state_ff == S_BUS);
  assign bus_write = write_ff;
  assign running = run_ff;
  assign op_done = (state_ff == S_DONE);
  // loads as the done state is left, so it trails op_done by one cycle
  assign op_clocks = done_cnt_ff;

endmodule : its_sequencer
`default_nettype wire

// file: sim/its_sequencer_monitor.sv
// checker for the instruction timing sequencer ports
`timescale 1ns/1ns
`default_nettype none
module its_sequencer_monitor
  import its_pkg::*;
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // pins and request
  input wire logic reset_in_b,
  input wire logic halt_in_b,
  input wire logic op_valid,
  input wire its_op_t op_code,
  input wire logic op_ready,
  input wire logic [ITS_CLK_W-1:0] ea_clks,
  input wire logic [ITS_CYC_W-1:0] ea_reads,
  input wire logic [ITS_CYC_W-1:0] ea_writes,
  // bus and status
  input wire logic bus_req,
  input wire logic bus_write,
  input wire logic bus_ack_b,
  input wire logic running,
  input wire logic op_done,
  input wire logic [ITS_CLK_W+1:0] op_clocks
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);
  // ********************************
  // timing relations
  // ********************************
  a_done_single: assert property (op_done |=> !op_done)
    else $error("done pulse longer than one cycle");
  a_done_then_ready: assert property (op_done && reset_in_b && halt_in_b |=> op_ready)
    else $error("not ready after done");
  a_bus_quad: assert property ($rose(bus_req) |-> bus_req [*4])
    else $error("bus cycle shorter than four clocks");
  a_idle_no_bus: assert property (op_ready |-> !bus_req && !op_done)
    else $error("bus active while idle");
  a_write_in_bus: assert property (bus_write |-> bus_req)
    else $error("write flag outside bus cycle");
  a_nop_walk: assert property (op_ready && op_valid && op_code == OP_NOP |=>
    bus_req [*4] ##1 op_done ##1 (op_clocks == 10'h004))
    else $error("no-operation timing wrong");
  a_halt_wait: assert property (op_ready && op_valid && op_code == OP_HALT_WAIT |=>
    !bus_req [*4] ##1 op_done)
    else $error("halt-until-interrupt timing wrong");
  a_halt_stops: assert property (!halt_in_b [*4] |-> !running && !bus_req)
    else $error("halt pin did not stop the core");
endmodule : its_sequencer_monitor

bind its_sequencer its_sequencer_monitor i_mon (.clk, .rst_b, .reset_in_b, .halt_in_b,
  .op_valid, .op_code, .op_ready, .ea_clks, .ea_reads, .ea_writes, .bus_req, .bus_write,
  .bus_ack_b, .running, .op_done, .op_clocks);
`default_nettype wire

// file: sim/its_bus_partner.sv
// bus partner model: answers each bus cycle, promptly or with wait states
`timescale 1ns/1ns
`default_nettype none
module its_bus_partner
(
  // clock and reset
  input wire logic clk,
  input wire logic rst_b,
  // bus side
  input wire logic bus_req,
  input wire logic slow,
  output logic bus_ack_b
);
  logic [3:0] wait_ff;
  logic [3:0] nxt_wait;
  // count bus clocks, saturating so a long stall cannot wrap
  always_comb
  begin
    nxt_wait = bus_req ? wait_ff + ((wait_ff != 4'hF) ? 4'h1 : 4'h0) : 4'h0;
  end
  always_ff @(posedge clk or negedge rst_b)
  begin
    if (!rst_b)
      wait_ff <= 4'h0;
    else
      wait_ff <= nxt_wait;
  end
  // pulled high when idle; a slow partner holds its answer off six clocks after bus_req rises, then answers back-to-back cycles at once
  assign bus_ack_b = !(bus_req && (!slow || wait_ff >= 4'h6));
endmodule : its_bus_partner
`default_nettype wire

// file: sim/tb_its_sequencer.sv
// testbench for the instruction timing sequencer
`timescale 1ns/1ns
`default_nettype none
module tb_its_sequencer
  import its_pkg::*;
;
  logic clk, rst_b, reset_in_b, halt_in_b, op_valid, op_ready, bus_req, bus_write, bus_ack_b;
  logic running, op_done, slow;
  its_op_t op_code;
  logic [ITS_CLK_W+1:0] op_clocks;
  logic [ITS_CLK_W-1:0] ea_clks;
  logic [ITS_CYC_W-1:0] ea_reads;
  logic [ITS_CYC_W-1:0] ea_writes;
  int n_errors = 0;
  int cmp_count = 0;
  // ********************************
  // design and far side
  // ********************************
  // address cost set per scenario: flagged entries grow, others must ignore it
  its_sequencer i_dut (.clk, .rst_b, .reset_in_b, .halt_in_b, .op_valid, .op_code, .op_ready,
    .ea_clks, .ea_reads, .ea_writes, .bus_req, .bus_write, .bus_ack_b,
    .running, .op_done, .op_clocks);
  its_bus_partner i_mem (.clk, .rst_b, .bus_req, .slow, .bus_ack_b);
  // ********************************
  // helpers
  // ********************************
  task automatic check(input bit ok, input string msg);
    cmp_count++;
    if (!ok)
    begin
      n_errors++;
      $display("[FAIL] %0t %s", $time, msg);
    end
  endtask : check
  task automatic summarize();
    if (n_errors == 0 && cmp_count > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : summarize
  // count clocks and bus clocks until done, bounded
  task automatic watch(output int k, output int nb, output int nw);
    k = 1;
    nb = bus_req;
    nw = bus_write;
    while (op_done !== 1'b1 && k < 400)
    begin
      @(negedge clk);
      k++;
      nb += bus_req;
      nw += bus_write;
    end
    if (k >= 400)
    begin
      check(1'b0, "no completion");
      summarize();
    end
  endtask : watch
  task automatic run_op(input its_op_t op, input int c, input int r, input int w, input bit s);
    int k, nb, nw;
    @(negedge clk);
    check(op_ready === 1'b1, "not ready");
    slow = s;
    op_valid = 1'b1;
    op_code = op;
    @(negedge clk);
    op_valid = 1'b0;
    watch(k, nb, nw);
    // the clock count register loads one cycle after the done pulse
    @(negedge clk);
    if (s)
      check(op_clocks > c && nb > 4 * (r + w), "wait states not counted");
    else
    begin
      check(k == c + 1 && op_clocks === 10'(c), "clock count");
      check(nb == 4 * (r + w) && nw == 4 * w, "bus cycle count");
    end
    slow = 1'b0;
  endtask : run_op
  task automatic startup();
    int k, nb, nw;
    @(negedge clk);
    reset_in_b = 1'b1;
    halt_in_b = 1'b1;
    watch(k, nb, nw);
    check(nb == 24 && nw == 0 && k >= 40 && k <= 46, "start-up sequence");
    check(running === 1'b1, "not running");
  endtask : startup
  // halt in mid-operation must abort back to the start-up wait
  task automatic abort_op();
    @(negedge clk);
    op_valid = 1'b1;
    op_code = OP_EXT_RESET;
    @(negedge clk);
    op_valid = 1'b0;
    repeat (20) @(negedge clk);
    halt_in_b = 1'b0;
    repeat (12) @(negedge clk);
    check(running === 1'b0 && bus_req === 1'b0, "halt did not abort");
    startup();
  endtask : abort_op
  // ********************************
  // clock and main sequence
  // ********************************
  initial
  begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  initial
  begin
    rst_b = 1'b0;
    reset_in_b = 1'b0;
    halt_in_b = 1'b0;
    op_valid = 1'b0;
    op_code = OP_NOP;
    slow = 1'b0;
    ea_clks = 8'h08;
    ea_reads = 4'h1;
    ea_writes = 4'h1;
    repeat (16) @(negedge clk);
    check(op_ready === 1'b0 && running === 1'b0 && op_done === 1'b0, "reset values");
    rst_b = 1'b1;
    repeat (3) @(negedge clk);
    check(running === 1'b0, "started with pins held");
    startup();
    run_op(OP_EXTENDED_ADD_RR_BW, 4, 1, 0, 0);
    run_op(OP_EXTENDED_SUBTRACT_RR_L, 8, 1, 0, 0);
    run_op(OP_EXTENDED_ADD_MM_L, 30, 5, 2, 0);
    run_op(OP_EXTENDED_SUBTRACT_MM_BW, 18, 3, 1, 0);
    run_op(OP_MEMORY_COMPARE_BW, 12, 3, 0, 0);
    run_op(OP_MEMORY_COMPARE_L, 20, 5, 0, 0);
    run_op(OP_DECIMAL_ADD_EXTEND_M, 18, 3, 1, 0);
    run_op(OP_DECIMAL_SUBTRACT_EXTEND_R, 6, 1, 0, 0);
    run_op(OP_XOR_IMM_STATUS, 20, 3, 0, 0);
    run_op(OP_AND_IMM_CODE, 20, 3, 0, 0);
    run_op(OP_EXT_RESET, 132, 1, 0, 0);
    run_op(OP_HALT_WAIT, 4, 0, 0, 0);
    run_op(OP_NOP, 4, 1, 0, 0);
    run_op(OP_REGISTER_EXCHANGE, 6, 1, 0, 0);
    run_op(OP_STATUS_READ_REG, 6, 1, 0, 0);
    run_op(OP_STATUS_WRITE, 20, 3, 1, 0);
    run_op(OP_LINK, 16, 2, 2, 0);
    run_op(OP_FRAME_UNLINK, 12, 3, 0, 0);
    run_op(OP_RETURN_RESTORE_CODES, 20, 2, 0, 0);
    run_op(OP_LANE_MOVE_L_RM, 24, 2, 4, 0);
    run_op(OP_LANE_MOVE_W_MR, 16, 4, 0, 0);
    run_op(OP_EXC_BUS_ERROR, 50, 4, 7, 0);
    run_op(OP_EXC_INTERRUPT, 44, 5, 3, 0);
    run_op(OP_EXC_OVERFLOW_TRAP, 34, 5, 3, 0);
    run_op(OP_EXC_TRAP, 34, 4, 3, 0);
    run_op(OP_EXC_BOUNDS_CHECK, 48, 5, 4, 0);
    run_op(OP_STATUS_READ_MEM, 16, 2, 2, 0);
    run_op(OP_EXC_ADDRESS_ERROR, 50, 4, 7, 0);
    run_op(OP_LANE_MOVE_L_MR, 24, 6, 0, 0);
    run_op(OP_EXCEPTION_RETURN, 20, 5, 0, 0);
    run_op(OP_SUB_RETURN, 16, 4, 0, 0);
    ea_clks = 8'h04;
    ea_reads = 4'h2;
    ea_writes = 4'h0;
    run_op(OP_EXC_DIVIDE_ZERO, 42, 6, 3, 0);
    run_op(OP_CODE_WRITE, 16, 3, 0, 0);
    run_op(OP_EXC_ILLEGAL, 34, 4, 3, 0);
    run_op(OP_LINK, 16, 2, 2, 1);
    abort_op();
    run_op(OP_NOP, 4, 1, 0, 0);
    summarize();
  end
endmodule : tb_its_sequencer
`default_nettype wire
